// file: verilog/spi_eeprom_serial_front_end.sv
// Purpose: Serial slave front end of a byte-organised SPI EEPROM.
// Assumes: Pins arrive asynchronously and are oversampled by clock_i.
// Notes: The instruction decoder lives in the core; it answers per opcode.
// Function
// RQ1 - Serial output changes on clock falling edges.
// RQ2 - Serial input captured on clock rising edges.
// RQ3 - Select high: deselected, output high impedance.
// RQ4 - Standby when deselected unless write running.
// RQ5 - Ignore instructions until first select falling edge.
// RQ6 - Pause: selected, output off, inputs ignored.
// RQ7 - Master pauses only while device selected.
// RQ8 - Master holds write-protect steady during writes.
// RQ9 - Write-protect freezes protected region size bits.
// RQ10 - Bytes are assembled most significant bit first.
// RQ11 - First bit taken on first rise after select.
// RQ12 - Read output starts first fall after instruction.
// RQ13 - Master uses mode zero or mode three.
// RQ14 - Same edges in both modes, no configuration.
// RQ15 - Array is 131072 byte-wide locations.
// RQ16 - Separate 256-byte lockable identification page.
// RQ17 - Unknown instruction: ignore bus until deselected.
// RQ18 - Deselect while paused resets logic except flags.
// RQ19 - Pause starts only when clock already low.
// RQ20 - Master raises select between last and next rise.
// RQ21 - After pause, shifting resumes at same bit.
`timescale 1ns/1ps
module spi_eeprom_serial_front_end
    import spi_fe_pkg::*;
#(
    parameter int MEM_LOCATIONS = spi_fe_pkg::MEM_BYTES,
    parameter int ID_LOCATIONS = spi_fe_pkg::ID_PAGE_BYTES
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Serial pins.
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    // Received bytes towards the core.
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [spi_fe_pkg::BYTE_W-1:0] rx_data_o,
    output logic rx_overrun_o,
    // Opcode report and the core's verdict on it.
    output logic opcode_valid_o,
    output logic [spi_fe_pkg::BYTE_W-1:0] opcode_o,
    input wire logic instr_known_i,
    input wire logic instr_read_i,
    // Bytes to send for read-type instructions.
    input wire logic [spi_fe_pkg::BYTE_W-1:0] tx_data_i,
    output logic tx_ready_o,
    // Frame and power state.
    output logic selected_o,
    output logic frame_end_o,
    output logic paused_o,
    output logic standby_o,
    input wire logic write_busy_i,
    // Protected region size bits.
    input wire logic prot_wr_i,
    input wire logic prot_size_hi_i,
    input wire logic prot_size_lo_i,
    output logic prot_size_hi_o,
    output logic prot_size_lo_o
);
    import spi_fe_pkg::*;

    // The array behind this front end is fixed in size.
    initial begin
        if (MEM_LOCATIONS != MEM_BYTES || ID_LOCATIONS != ID_PAGE_BYTES) begin // RQ15 RQ16
            $error("spi_eeprom_serial_front_end: unsupported array size.");
        end
    end

    // Two-flop synchronisers; only the second stage is read. Select starts
    // low in the chain, so a select held low through reset shows no fall.
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_reg <= 5'h1a;
            pin_sync_reg <= 5'h1a;
        end else begin
            pin_meta_reg <= {wp_n_i, hold_n_i, cs_n_i, sdi_i, sclk_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic sclk_s;
    logic sdi_s;
    logic cs_n_s;
    logic hold_n_s;
    logic wp_n_s;
    assign {wp_n_s, hold_n_s, cs_n_s, sdi_s, sclk_s} = pin_sync_reg;

    // Previous levels for edge detection. Select resets to low so that a
    // select already low at power-up does not look like a falling edge.
    logic sclk_prev_reg;
    logic cs_n_prev_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_prev_reg <= 1'b0;
            cs_n_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            cs_n_prev_reg <= cs_n_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    assign cs_fall = cs_n_prev_reg && !cs_n_s;
    assign cs_rise = !cs_n_prev_reg && cs_n_s;
    // Edges are taken from the pin alone, so idle-low and idle-high masters
    // both work without a mode setting.
    assign sclk_rise = !sclk_prev_reg && sclk_s; // RQ14
    assign sclk_fall = sclk_prev_reg && !sclk_s; // RQ14

    // Armed after the first select falling edge since reset.
    logic armed_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_reg <= 1'b0;
        end else if (cs_fall) begin
            armed_reg <= 1'b1; // RQ5
        end
    end

    logic active;
    assign active = armed_reg && !cs_n_s; // RQ4 RQ5

    // Pause: entered only on a hold fall while the clock is low, left when
    // hold returns high. Deselect clears it with the rest of the frame.
    logic paused_reg;
    logic hold_prev_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            paused_reg <= 1'b0;
            hold_prev_reg <= 1'b1;
        end else begin
            hold_prev_reg <= hold_n_s;
            if (!active) begin
                paused_reg <= 1'b0; // RQ18
            end else if (hold_prev_reg && !hold_n_s && !sclk_s) begin
                paused_reg <= 1'b1; // RQ19
            end else if (hold_n_s) begin
                paused_reg <= 1'b0;
            end
        end
    end

    // Clock edges count only while selected and not paused; counters are
    // simply frozen during a pause so no bit is lost or repeated.
    logic take_rise;
    logic take_fall;
    assign take_rise = active && !paused_reg && sclk_rise; // RQ6 RQ21
    assign take_fall = active && !paused_reg && sclk_fall; // RQ6 RQ21

    // Frame state.
    fe_state_e state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic byte_done;
    logic [7:0] byte_next;
    assign byte_next = {rx_shift_reg[6:0], sdi_s}; // RQ10
    assign byte_done = take_rise && (bit_cnt_reg == BIT_LAST) &&
                       (state_reg != ST_WAIT) && (state_reg != ST_IDLE);

    // Input shifter: the very first rise after select carries bit 7.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt_reg <= BIT_CNT_RST;
            rx_shift_reg <= BYTE_RST;
        end else if (!active) begin
            bit_cnt_reg <= BIT_CNT_RST; // RQ18
        end else if (take_rise && state_reg != ST_WAIT) begin
            rx_shift_reg <= byte_next; // RQ2 RQ11
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Read phase is decided at the first fall after the opcode byte.
    logic opcode_seen_reg;
    logic read_phase_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= ST_IDLE;
            opcode_seen_reg <= 1'b0;
            read_phase_reg <= 1'b0;
        end else if (!active) begin
            state_reg <= ST_IDLE;
            opcode_seen_reg <= 1'b0;
            read_phase_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_OPCODE;
                end
                ST_OPCODE: begin
                    if (byte_done) begin
                        opcode_seen_reg <= 1'b1;
                    end
                    if (opcode_seen_reg && take_fall) begin
                        if (!instr_known_i) begin
                            state_reg <= ST_WAIT; // RQ17
                        end else begin
                            state_reg <= ST_DATA;
                            read_phase_reg <= instr_read_i; // RQ12
                        end
                    end
                end
                ST_DATA: begin
                    state_reg <= ST_DATA;
                end
                ST_WAIT: begin
                    state_reg <= ST_WAIT; // RQ17
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Opcode report, one-cycle strobe with a held value.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            opcode_valid_o <= 1'b0;
            opcode_o <= BYTE_RST;
        end else begin
            opcode_valid_o <= byte_done && !opcode_seen_reg && state_reg == ST_OPCODE;
            if (byte_done && !opcode_seen_reg) begin
                opcode_o <= byte_next; // RQ10
            end
        end
    end

    // Received bytes go through the buffer; the master cannot be stalled,
    // so a byte arriving while the buffer is full is flagged as overrun.
    logic buf_in_ready;
    byte_buffer #(
        .WIDTH(BYTE_W),
        .DEPTH(RX_BUF_DEPTH)
    ) u_rx_buf (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_valid_i(byte_done),
        .in_ready_o(buf_in_ready),
        .in_data_i(byte_next),
        .out_ready_i(rx_ready_i),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .flush_i(cs_fall)
    );

    // Overrun is sticky until the next frame starts.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_overrun_o <= 1'b0;
        end else if (byte_done && !buf_in_ready) begin
            rx_overrun_o <= 1'b1;
        end else if (cs_fall) begin
            rx_overrun_o <= 1'b0;
        end
    end

    // Output shifter: a new byte is loaded at every eighth fall.
    logic [2:0] tx_cnt_reg;
    logic [7:0] tx_shift_reg;
    logic tx_load;
    logic tx_fall;
    assign tx_fall = take_fall && (read_phase_reg ||
        (state_reg == ST_OPCODE && opcode_seen_reg && instr_known_i && instr_read_i));
    assign tx_load = tx_fall && (tx_cnt_reg == BIT_CNT_RST);
    assign tx_ready_o = tx_load;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_cnt_reg <= BIT_CNT_RST;
            tx_shift_reg <= BYTE_RST;
            sdo_o <= 1'b0;
        end else if (!active) begin
            tx_cnt_reg <= BIT_CNT_RST;
        end else if (tx_fall) begin
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
            if (tx_load) begin
                sdo_o <= tx_data_i[7]; // RQ1 RQ12
                tx_shift_reg <= {tx_data_i[6:0], 1'b0};
            end else begin
                sdo_o <= tx_shift_reg[7]; // RQ1 RQ10
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    // Driver enable: off while deselected, paused or not reading.
    logic tx_started_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_started_reg <= 1'b0;
        end else if (!active) begin
            tx_started_reg <= 1'b0;
        end else if (tx_load) begin
            tx_started_reg <= 1'b1;
        end
    end
    assign sdo_oe_o = active && !paused_reg && tx_started_reg; // RQ3 RQ6

    // Protected size bits only move while write-protect is high.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {prot_size_hi_o, prot_size_lo_o} <= PROT_SIZE_RST;
        end else if (prot_wr_i && wp_n_s) begin
            {prot_size_hi_o, prot_size_lo_o} <= {prot_size_hi_i, prot_size_lo_i}; // RQ9
        end
    end

    // Status outputs. A select rise before arming is the synchroniser
    // leaving its reset level, not the end of a frame.
    assign selected_o = active;
    assign paused_o = paused_reg;
    assign frame_end_o = cs_rise && armed_reg; // RQ5
    assign standby_o = cs_n_s && !write_busy_i; // RQ4
endmodule

// file: verilog/spi_fe_pkg.sv
// Purpose: Shared constants for the serial EEPROM front end.
// Assumes: Nothing beyond plain SystemVerilog.
// Notes: Memory sizes describe the array that sits behind this front end.
package spi_fe_pkg;
    // Byte-wide array: number of locations and width of one location.
    localparam int MEM_BYTES = 131072;
    localparam int MEM_ADDR_W = 17;
    localparam int BYTE_W = 8;
    // Separate lockable identification page.
    localparam int ID_PAGE_BYTES = 256;
    localparam int ID_ADDR_W = 8;
    // Depth of the receive buffer between the serial side and the core.
    localparam int RX_BUF_DEPTH = 2;
    // Synchroniser length for every pin input.
    localparam int SYNC_STAGES = 2;
    // Reset values.
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] PROT_SIZE_RST = 2'h0;
    // Serial bit counter value that marks the last bit of a byte.
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Front end states.
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_OPCODE = 4'b0010,
        ST_DATA   = 4'b0100,
        ST_WAIT   = 4'b1000
    } fe_state_e;
endpackage

// file: verilog/byte_buffer.sv
// Purpose: Small valid/ready buffer that holds received bytes for the core.
// Assumes: Both sides on the same clock.
// Notes: Full and empty are exact; a push while full is refused.
`timescale 1ns/1ps
module byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Filling side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side.
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    // Flush, clears every entry.
    input wire logic flush_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // The pointer arithmetic below wraps naturally only for powers of two.
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("byte_buffer: DEPTH must be a power of two, at least 2.");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;
    logic [AW:0] rd_ptr_next;

    // Full when pointers differ only in the wrap bit; empty when equal.
    assign in_ready_o = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                          (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Head position after this cycle's pop.
    assign rd_ptr_next = rd_ptr_reg + {{AW{1'b0}}, pop};

    // Storage has no reset; nothing reads an entry before it is written.
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (flush_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // Output register shows the head in the cycle valid does. A byte pushed
    // into an emptying buffer bypasses the array, whose write lands only now.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_data_o <= '0;
        end else if (push && wr_ptr_reg[AW-1:0] == rd_ptr_next[AW-1:0]) begin
            out_data_o <= in_data_i;
        end else begin
            out_data_o <= mem_reg[rd_ptr_next[AW-1:0]];
        end
    end
endmodule

// file: tb/spi_fe_props.sv
// Purpose: Port-level checks for the serial EEPROM front end.
// Assumes: Pins stay put for several system clocks between changes.
// Notes: Pins pass a two-stage synchroniser, hence the short waits below.
`timescale 1ns/1ps
module spi_fe_props
    import spi_fe_pkg::*;
#(
    parameter int MEM_LOCATIONS = spi_fe_pkg::MEM_BYTES,
    parameter int ID_LOCATIONS = spi_fe_pkg::ID_PAGE_BYTES
) (
    // Clock, reset and pins.
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    // Core side.
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [spi_fe_pkg::BYTE_W-1:0] rx_data_o,
    input wire logic [spi_fe_pkg::BYTE_W-1:0] tx_data_i,
    input wire logic tx_ready_o,
    input wire logic selected_o,
    input wire logic frame_end_o,
    input wire logic paused_o,
    input wire logic standby_o,
    input wire logic write_busy_i,
    // Protection bits.
    input wire logic prot_wr_i,
    input wire logic prot_size_hi_i,
    input wire logic prot_size_lo_i,
    input wire logic prot_size_hi_o,
    input wire logic prot_size_lo_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Top bit offered by the core, one cycle late, to match the output load.
    logic msb_reg;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            msb_reg <= 1'b0;
        end else begin
            msb_reg <= tx_data_i[7];
        end
    end
    // Pin levels must get through the synchroniser before outputs follow.
    sequence s_cs_high; cs_n_i [*5]; endsequence
    sequence s_cs_low; !cs_n_i [*5]; endsequence
    sequence s_wp_open; wp_n_i [*4] ##0 prot_wr_i; endsequence
    chk_desel_hiz: assert property (s_cs_high |-> !sdo_oe_o)
        else $error("serial output driven while deselected");
    chk_standby_on: assert property (s_cs_high ##0 !write_busy_i [*3] |-> standby_o)
        else $error("standby missing while idle");
    chk_active_mode: assert property (s_cs_low |-> !standby_o)
        else $error("standby while selected");
    chk_frame_end: assert property ($rose(cs_n_i) && selected_o |-> ##[1:4] frame_end_o)
        else $error("frame end pulse missing");
    chk_pause_hiz: assert property (paused_o |-> !sdo_oe_o)
        else $error("serial output driven in pause");
    chk_pause_entry: assert property ($rose(paused_o) |-> selected_o && !$past(sclk_i, 3))
        else $error("pause entered with clock high or deselected");
    chk_sdo_on_fall: assert property ($changed(sdo_o) && sdo_oe_o |-> !sclk_i && !$past(sclk_i, 2))
        else $error("serial output moved without a clock fall");
    chk_load_msb: assert property (tx_ready_o |=> sdo_oe_o && sdo_o == msb_reg)
        else $error("first output bit is not the top bit");
    chk_prot_frozen: assert property (!wp_n_i [*4] |=> $stable(prot_size_hi_o) && $stable(prot_size_lo_o))
        else $error("protect size changed while frozen");
    chk_prot_load: assert property (s_wp_open |=> prot_size_hi_o == $past(prot_size_hi_i) && prot_size_lo_o == $past(prot_size_lo_i))
        else $error("protect size not loaded");
    chk_rx_stall: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("received byte lost under stall");
endmodule
bind spi_eeprom_serial_front_end spi_fe_props #(
    .MEM_LOCATIONS(MEM_LOCATIONS),
    .ID_LOCATIONS(ID_LOCATIONS)
) props (
    .clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o), .selected_o(selected_o), .frame_end_o(frame_end_o),
    .paused_o(paused_o), .standby_o(standby_o), .write_busy_i(write_busy_i),
    .prot_wr_i(prot_wr_i), .prot_size_hi_i(prot_size_hi_i),
    .prot_size_lo_i(prot_size_lo_i), .prot_size_hi_o(prot_size_hi_o),
    .prot_size_lo_o(prot_size_lo_o)
);

// file: tb/spi_master_model.sv
// Purpose: Behavioural bus master that clocks frames into the front end.
// Assumes: Tasks are entered on a falling system clock edge.
// Notes: Half period 80 ns keeps every pin change on a falling system edge.
`timescale 1ns/1ps
module spi_master_model (
    // Pins driven by the master.
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    output logic hold_n_o,
    // Data line as resolved on the board.
    input wire logic sdo_line_i
);
    localparam int HALF_NS = 80;
    logic cpol;
    // Idle bus: deselected, clock parked low.
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        hold_n_o = 1'b1;
        cpol = 1'b0;
    end
    // Park the clock at the mode's idle level before selecting.
    task automatic select(input logic mode3);
        cpol = mode3;
        sclk_o = mode3;
        #(HALF_NS);
        cs_n_o = 1'b0;
        #(HALF_NS);
    endtask
    // Deselect after the last rise and before any further rise.
    task automatic deselect();
        #(HALF_NS);
        sclk_o = cpol;
        #(HALF_NS);
        cs_n_o = 1'b1;
        #(2 * HALF_NS);
    endtask
    // Shift n bits top first; hold falls with the clock low, and clock and data moves while paused are ignored.
    task automatic bits(input logic [7:0] v, input int n, input int hold_at, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0;
            sdi_o = v[7-i];
            #(HALF_NS);
            if (i == hold_at) begin
                hold_n_o = 1'b0;
                repeat (2) begin
                    #(HALF_NS);
                    sclk_o = 1'b1;
                    sdi_o = !sdi_o;
                    #(HALF_NS);
                    sclk_o = 1'b0;
                end
                #(HALF_NS);
                hold_n_o = 1'b1;
                #(HALF_NS);
            end
            sclk_o = 1'b1;
            r = {r[6:0], sdo_line_i};
            #(HALF_NS);
        end
    endtask
    // Pause, then drop select while still paused.
    task automatic abort_in_pause();
        sclk_o = 1'b0;
        #(HALF_NS);
        hold_n_o = 1'b0;
        #(2 * HALF_NS);
        cs_n_o = 1'b1;
        #(2 * HALF_NS);
        hold_n_o = 1'b1;
        #(2 * HALF_NS);
    endtask
endmodule

// file: tb/tb_spi_eeprom_serial_front_end.sv
// Purpose: Self-checking bench for the serial EEPROM front end.
// Assumes: Opcode 03 reads, ff is unknown, all else is a plain write.
// Notes: The link clock stands still between frames.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_spi_eeprom_serial_front_end;
    import spi_fe_pkg::*;
    logic clock_i = 1'b0, resetn_i = 1'b0, sclk, cs_n, sdi, hold_n, sdo, sdo_oe;
    logic wp_n = 1'b1, rx_valid, rx_ready = 1'b1, rx_overrun, opcode_valid, tx_ready;
    logic paused, standby, write_busy = 1'b0, prot_wr = 1'b0, phi = 1'b0, plo = 1'b0;
    logic phi_o, plo_o, known, is_read;
    logic [7:0] rx_data, opcode, r, tx_data = 8'h00;
    logic [7:0] rxq[$];
    int fail_count = 0, checks_done = 0, op_count = 0;
    // Pulled-up data line; core verdict follows the held opcode.
    wire sdo_line = sdo_oe ? sdo : 1'b1;
    assign known = (opcode !== 8'hff);
    assign is_read = (opcode === 8'h03);
    initial begin
        forever #4 clock_i = !clock_i;
    end
    // Every byte the core takes, and every opcode report.
    always @(posedge clock_i) begin
        if (rx_valid && rx_ready) rxq.push_back(rx_data);
        if (opcode_valid) op_count++;
    end
    spi_master_model m (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .hold_n_o(hold_n),
        .sdo_line_i(sdo_line));
    spi_eeprom_serial_front_end dut (.clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .hold_n_i(hold_n),
        .wp_n_i(wp_n), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
        .rx_overrun_o(rx_overrun), .opcode_valid_o(opcode_valid), .opcode_o(opcode),
        .instr_known_i(known), .instr_read_i(is_read), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .selected_o(), .frame_end_o(), .paused_o(paused),
        .standby_o(standby), .write_busy_i(write_busy), .prot_wr_i(prot_wr),
        .prot_size_hi_i(phi), .prot_size_lo_i(plo), .prot_size_hi_o(phi_o),
        .prot_size_lo_o(plo_o));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic t_write(input logic mode3);
        int p0;
        rxq.delete();
        p0 = op_count;
        m.select(mode3);
        m.bits(8'h02, 8, -1, r);
        m.bits(8'ha5, 8, -1, r);
        m.bits(8'h3c, 8, -1, r);
        m.deselect();
        `CHK("opcode", 8'h02, opcode)
        `CHK("opcode strobes", p0 + 1, op_count)
        `CHK("rx last", 8'h3c, rxq[$])
        `CHK("rx prev", 8'ha5, rxq[$-1])
    endtask
    // Stalled core: the buffer fills, refuses, then drains empty.
    task automatic t_stall();
        rx_ready = 1'b0;
        rxq.delete();
        m.select(1'b1);
        foreach (tx_data[i]) if (i < 4) m.bits(8'(8'h11 * (i + 1)), 8, -1, r);
        m.deselect();
        `CHK("overrun", 1'b1, rx_overrun)
        @(negedge clock_i) rx_ready = 1'b1;
        repeat (6) @(negedge clock_i);
        `CHK("drained", 2, rxq.size())
        `CHK("empty", 1'b0, rx_valid)
    endtask
    task automatic t_read(input logic mode3, input int hold_at);
        tx_data = 8'hc6;
        m.select(mode3);
        `CHK("overrun cleared", 1'b0, rx_overrun)
        m.bits(8'h03, 8, -1, r);
        fork
            m.bits(8'h00, 8, hold_at, r);
            if (hold_at >= 0) begin
                wait (hold_n === 1'b0);
                repeat (8) @(negedge clock_i);
                `CHK("paused", 1'b1, paused)
                `CHK("oe in pause", 1'b0, sdo_oe)
            end
        join
        m.deselect();
        `CHK("read byte", 8'hc6, r)
        `CHK("oe idle", 1'b0, sdo_oe)
    endtask
    task automatic t_unknown();
        int s0;
        m.select(1'b0);
        m.bits(8'hff, 8, -1, r);
        s0 = rxq.size();
        m.bits(8'h55, 8, -1, r);
        m.deselect();
        `CHK("unknown line", 8'hff, r)
        `CHK("unknown rx", s0, rxq.size())
    endtask
    // Reset with select low: no select fall follows, so the frame is ignored.
    task automatic t_unarmed();
        int p0;
        m.select(1'b0);
        resetn_i = 1'b0;
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        rxq.delete();
        p0 = op_count;
        m.bits(8'h03, 8, -1, r);
        m.deselect();
        `CHK("unarmed opcode", p0, op_count)
        `CHK("unarmed rx", 0, rxq.size())
        `CHK("unarmed line", 8'hff, r)
    endtask
    task automatic t_abort();
        m.select(1'b0);
        m.bits(8'h03, 8, -1, r);
        m.abort_in_pause();
        `CHK("pause cleared", 1'b0, paused)
        t_read(1'b0, -1);
    endtask
    task automatic t_standby();
        @(negedge clock_i) write_busy = 1'b1;
        repeat (6) @(negedge clock_i);
        `CHK("standby busy", 1'b0, standby)
        write_busy = 1'b0;
        repeat (6) @(negedge clock_i);
        `CHK("standby idle", 1'b1, standby)
        m.select(1'b0);
        `CHK("active", 1'b0, standby)
        m.deselect();
    endtask
    task automatic prot(input logic w, input logic [1:0] v, input logic [1:0] e);
        @(negedge clock_i) wp_n = w;
        repeat (5) @(negedge clock_i);
        {phi, plo} = v;
        prot_wr = 1'b1;
        @(negedge clock_i) prot_wr = 1'b0;
        `CHK("prot size", e, {phi_o, plo_o})
    endtask
    initial begin
        repeat (16) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        t_unarmed();
        t_write(1'b0);
        t_write(1'b1);
        t_stall();
        t_read(1'b0, -1);
        t_read(1'b1, -1);
        t_read(1'b0, 3);
        t_read(1'b1, 0);
        t_unknown();
        t_abort();
        t_standby();
        prot(1'b1, 2'h2, 2'h2);
        prot(1'b0, 2'h1, 2'h2);
        prot(1'b1, 2'h1, 2'h1);
        final_report();
    end
    // Watchdog: the sequence needs roughly a tenth of this.
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
endmodule
